// ==== logic/urx_pkg.sv ====
// Package with register layout, modes and constants of the receive endpoint status block.
package urx_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] URX_OFS_CSR = 4'h0;
    localparam logic [3:0] URX_OFS_CFG = 4'h4;
    localparam logic [3:0] URX_OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] URX_OFS_IRQ_CLR = 4'hC;
    localparam logic [3:0] URX_OFS_IRQ_EN = 4'h1;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int URX_BIT_DROP = 18;
    localparam int URX_BIT_FULL = 17;
    localparam int URX_BIT_RDY = 16;
    localparam int URX_PAYLOAD_MULTIPLIER_LSB = 11;
    localparam int URX_PAYLOAD_MULTIPLIER_W = 5;
    localparam int URX_MAXP_W = 11;
    localparam int URX_CFG_HOST = 0;
    localparam int URX_CFG_TYPE_LSB = 1;
    localparam int URX_CFG_HS = 3;
    localparam int URX_CFG_MAX_TX_PAYLOAD_BYTES_LSB = 16;
    localparam int URX_IRQ_RDY = 0;
    localparam int URX_IRQ_ERR = 1;
    localparam int URX_IRQ_DROP = 2;
    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [4:0] URX_PAYLOAD_MULTIPLIER_RST = 5'h00;
    localparam logic [10:0] URX_MAXP_RST = 11'h000;
    localparam logic [1:0] URX_TRIES_LIMIT = 2'h3;
    localparam logic [3:0] URX_SLOTS = 4'h2;
    typedef enum logic [1:0] {
        URX_CTRL = 2'h0,
        URX_ISO = 2'h1,
        URX_BULK = 2'h2,
        URX_INTR = 2'h3
    } urx_xfer_t;
endpackage

// ==== logic/urx_ev_if.sv ====
// Interface carrying link events and slot state between the block and its slot counter.
`timescale 1ns/10ps
`default_nettype none
interface urx_ev_if;
    logic pkt_rcvd;
    logic pkt_fail;
    logic slot_full;
    logic pop;
    logic [3:0] used;
    modport src (output pkt_rcvd, output pkt_fail, output pop, input slot_full, input used);
    modport dst (input pkt_rcvd, input pkt_fail, input pop, output slot_full, output used);
endinterface
`default_nettype wire

// ==== logic/urx_slots.sv ====
// Packet slot counter of the receive queue.
`timescale 1ns/10ps
`default_nettype none
module urx_slots
    import urx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    urx_ev_if.dst ev
);
    logic [3:0] used_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            used_q <= 4'h0;
        end else if (ev.pkt_rcvd && (used_q != URX_SLOTS) && !ev.pop) begin
            used_q <= used_q + 4'h1;
        end else if (ev.pop && !ev.pkt_rcvd && (used_q != 4'h0)) begin
            used_q <= used_q - 4'h1;
        end
    end
    assign ev.used = used_q;
    assign ev.slot_full = (used_q == URX_SLOTS);
endmodule // urx_slots
`default_nettype wire

// ==== logic/urx_top.sv ====
// Receive endpoint status and control block with register port.
//
// What this block does
// - Device role, isochronous: set drop flag when OUT packet finds queue full.
// - Device role, bulk: drop flag reads as zero.
// - Host role, non-isochronous: three failed receive attempts set error flag and interrupt.
// - Error flag reads zero for isochronous endpoints.
// - Full bit is one when no packet slot remains, else zero.
// - Received packet sets ready flag and interrupt unless the queue is full with no pop; software writes zero to clear.
// - Effective payload is transmit max payload times multiplier plus one.
// - Bulk multiplier plus one gives number of bus packets one queue packet splits into.
// - High speed periodic: multiplier 2 or 3 bounds transactions per microframe.
// - Bits 10 to 0 hold max receive payload bytes per transaction.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module urx_top
    import urx_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic pkt_rcvd_i,
    input wire logic pkt_fail_i,
    input wire logic pkt_pop_i,
    output logic [15:0] payload_o,
    output logic [5:0] split_cnt_o,
    output logic [5:0] uframe_max_o,
    output logic irq_o
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rst_a_q;
    logic rst_n;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_a_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n <= rst_a_q;
        end
    end

    // ****************************************
    // Configuration and control
    // ****************************************
    logic [4:0] payload_multiplier_q;
    logic [10:0] maxp_q;
    logic host_q;
    logic hs_q;
    urx_xfer_t type_q;
    logic [10:0] max_tx_payload_bytes_q;
    logic [2:0] irq_en_q;
    logic wr_csr;
    assign wr_csr = wr_i && (addr_i == URX_OFS_CSR);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            payload_multiplier_q <= URX_PAYLOAD_MULTIPLIER_RST;
            maxp_q <= URX_MAXP_RST;
        end else if (wr_csr) begin
            payload_multiplier_q <= wdata_i[URX_PAYLOAD_MULTIPLIER_LSB +: URX_PAYLOAD_MULTIPLIER_W];
            maxp_q <= wdata_i[URX_MAXP_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            host_q <= 1'b0;
            hs_q <= 1'b0;
            type_q <= URX_BULK;
            max_tx_payload_bytes_q <= URX_MAXP_RST;
        end else if (wr_i && (addr_i == URX_OFS_CFG)) begin
            host_q <= wdata_i[URX_CFG_HOST];
            hs_q <= wdata_i[URX_CFG_HS];
            type_q <= urx_xfer_t'(wdata_i[URX_CFG_TYPE_LSB +: 2]);
            max_tx_payload_bytes_q <= wdata_i[URX_CFG_MAX_TX_PAYLOAD_BYTES_LSB +: URX_MAXP_W];
        end
    end

    // ****************************************
    // Slot tracking
    // ****************************************
    urx_ev_if ev ();
    assign ev.pkt_rcvd = pkt_rcvd_i;
    assign ev.pkt_fail = pkt_fail_i;
    assign ev.pop = pkt_pop_i;
    urx_slots u_slots (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ev(ev)
    );

    // ****************************************
    // Status flags
    // ****************************************
    logic iso;
    logic rdy_q;
    logic drop_q;
    logic err_q;
    logic [1:0] tries_q;
    logic clr_rdy;
    logic clr_drop;
    logic set_rdy;
    logic set_drop;
    logic set_err;
    assign iso = (type_q == URX_ISO);
    // Writing one is a no-op, so software can rewrite the word without losing events.
    assign clr_rdy = wr_csr && !wdata_i[URX_BIT_RDY];
    assign clr_drop = wr_csr && !wdata_i[URX_BIT_DROP];
    assign set_rdy = pkt_rcvd_i && !(ev.slot_full && !pkt_pop_i);
    assign set_drop = !host_q && iso && pkt_rcvd_i && ev.slot_full && !pkt_pop_i;
    assign set_err = host_q && !iso && pkt_fail_i && (tries_q == URX_TRIES_LIMIT - 2'h1);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdy_q <= 1'b0;
        end else if (set_rdy) begin
            rdy_q <= 1'b1;
        end else if (clr_rdy) begin
            rdy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            drop_q <= 1'b0;
        end else if (set_drop) begin
            drop_q <= 1'b1;
        end else if (clr_drop && !host_q) begin
            drop_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else if (set_err) begin
            err_q <= 1'b1;
        end else if (clr_drop && host_q) begin
            err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tries_q <= 2'h0;
        end else if (pkt_rcvd_i || set_err) begin
            tries_q <= 2'h0;
        end else if (host_q && pkt_fail_i) begin
            tries_q <= tries_q + 2'h1;
        end
    end

    // Bit 18 shares drop and error meanings; role selects one and type masks it where it cannot apply.
    logic bit18;
    always_comb begin
        if (host_q) begin
            bit18 = err_q && !iso;
        end else begin
            bit18 = drop_q && iso;
        end
    end

    // ****************************************
    // Payload arithmetic
    // ****************************************
    function automatic logic [15:0] urx_scale(input logic [10:0] p, input logic [4:0] m);
        logic [16:0] prod;
        prod = {6'h00, p} * ({12'h000, m} + 17'h00001);
        return prod[15:0];
    endfunction

    logic [5:0] payload_multiplier_p1;
    assign payload_multiplier_p1 = {1'b0, payload_multiplier_q} + 6'h01;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            payload_o <= 16'h0000;
            split_cnt_o <= 6'h01;
            uframe_max_o <= 6'h01;
        end else begin
            payload_o <= urx_scale(max_tx_payload_bytes_q, payload_multiplier_q);
            split_cnt_o <= (type_q == URX_BULK) ? payload_multiplier_p1 : 6'h01;
            // Only 2 or 3 are legal at high speed; every value other than 2 gives 3.
            if (hs_q && (type_q == URX_ISO || type_q == URX_INTR)) begin
                uframe_max_o <= (payload_multiplier_q == 5'h02) ? 6'h02 : 6'h03;
            end else begin
                uframe_max_o <= 6'h01;
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    logic [2:0] ist_q;
    logic [2:0] ist_set;
    assign ist_set = {set_drop, set_err, set_rdy};
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ist_q <= 3'h0;
        end else if (wr_i && addr_i == URX_OFS_IRQ_CLR) begin
            ist_q <= ist_set | (ist_q & ~wdata_i[2:0]);
        end else begin
            ist_q <= ist_q | ist_set;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q <= 3'h0;
        end else if (wr_i && addr_i == URX_OFS_IRQ_EN) begin
            irq_en_q <= wdata_i[2:0];
        end
    end
    assign irq_o = |(ist_q & irq_en_q);

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            unique case (addr_i)
                URX_OFS_CSR: rdata_o <= {13'h0000, bit18, ev.slot_full, rdy_q,
                                         payload_multiplier_q, maxp_q};
                URX_OFS_CFG: rdata_o <= {5'h00, max_tx_payload_bytes_q, 12'h000, hs_q, type_q, host_q};
                URX_OFS_IRQ_STAT: rdata_o <= {29'h0000_0000, ist_q};
                URX_OFS_IRQ_EN: rdata_o <= {29'h0000_0000, irq_en_q};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_full_bit: assert property (@(posedge clk_i) disable iff (!rst_n)
        ev.pkt_rcvd && !ev.pop && ev.used == URX_SLOTS - 4'h1 |=> ev.slot_full)
        else $error("full bit not set when last slot filled");
    a_rdy_set: assert property (@(posedge clk_i) disable iff (!rst_n)
        set_rdy |=> rdy_q)
        else $error("ready flag not set after packet");
    a_rdy_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
        rdy_q && !clr_rdy |=> rdy_q)
        else $error("ready flag dropped without clear");
    a_drop_bulk: assert property (@(posedge clk_i) disable iff (!rst_n)
        !host_q && type_q == URX_BULK |-> !bit18)
        else $error("drop flag visible in bulk mode");
    a_err_iso: assert property (@(posedge clk_i) disable iff (!rst_n)
        host_q && iso |-> !bit18)
        else $error("error flag visible in iso mode");
    a_err_three: assert property (@(posedge clk_i) disable iff (!rst_n)
        host_q && !iso && !err_q && pkt_fail_i && !pkt_rcvd_i ##1 pkt_fail_i && !pkt_rcvd_i
        ##1 pkt_fail_i && !pkt_rcvd_i && $stable(type_q) && host_q |=> err_q)
        else $error("error flag not set after three failures");
    a_drop_set: assert property (@(posedge clk_i) disable iff (!rst_n)
        set_drop |=> drop_q ##1 (drop_q || $past(clr_drop)))
        else $error("drop flag not set on overrun");
    a_payload_calc: assert property (@(posedge clk_i) disable iff (!rst_n)
        $stable(max_tx_payload_bytes_q) && $stable(payload_multiplier_q) |=> payload_o == ({5'h00, $past(max_tx_payload_bytes_q)}
        * ({11'h000, $past(payload_multiplier_q)} + 16'h0001)))
        else $error("payload size wrong");
    a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n)
        set_rdy && irq_en_q[URX_IRQ_RDY] |=> irq_o)
        else $error("interrupt not raised on ready");
    c_rdy: cover property (@(posedge clk_i) disable iff (!rst_n) set_rdy ##1 clr_rdy);
    c_drop: cover property (@(posedge clk_i) disable iff (!rst_n) set_drop);
    c_err: cover property (@(posedge clk_i) disable iff (!rst_n) set_err ##[1:5] irq_o);
endmodule // urx_top
`default_nettype wire

// ==== verification/urx_link_model.sv ====
// Link partner model that delivers data packets and failed receive attempts.
`timescale 1ns/10ps
`default_nettype none
module urx_link_model (
    input wire logic clk_i,
    output logic pkt_rcvd_o,
    output logic pkt_fail_o
);
    int gap_cyc = 0;
    initial begin
        pkt_rcvd_o = 1'b0;
        pkt_fail_o = 1'b0;
    end
    // One attempt per call. A slow partner leaves gap_cyc idle cycles after it.
    task automatic send_pkt(input bit ok);
        @(posedge clk_i);
        pkt_rcvd_o <= ok;
        pkt_fail_o <= !ok;
        @(posedge clk_i);
        pkt_rcvd_o <= 1'b0;
        pkt_fail_o <= 1'b0;
        repeat (gap_cyc) @(posedge clk_i);
    endtask
    // Back-to-back failed attempts, one per cycle, with no idle cycle between them.
    task automatic send_fails(input int n);
        @(posedge clk_i);
        pkt_fail_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        pkt_fail_o <= 1'b0;
    endtask
endmodule // urx_link_model
`default_nettype wire

// ==== verification/test_urx_top.sv ====
// Self-checking testbench of the receive endpoint status block.
`timescale 1ns/10ps
`default_nettype none
module test_urx_top;
    import urx_pkg::*;
    logic clk = 1'b0;
    logic nrst;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic pop;
    logic [31:0] rdata;
    logic rcvd;
    logic fail;
    logic [15:0] payload;
    logic [5:0] split;
    logic [5:0] ufr;
    logic irq;
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [4:0] mults [4] = '{5'h00, 5'h02, 5'h03, 5'h1F};
    logic [5:0] exp_s;
    logic [5:0] exp_u;
    always #2 clk = ~clk;
    urx_link_model link (.clk_i(clk), .pkt_rcvd_o(rcvd), .pkt_fail_o(fail));
    urx_top dut_u (.clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .pkt_rcvd_i(rcvd), .pkt_fail_i(fail), .pkt_pop_i(pop),
        .payload_o(payload), .split_cnt_o(split), .uframe_max_o(ufr), .irq_o(irq));
    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask
    task automatic pop_pkt();
        @(posedge clk);
        pop <= 1'b1;
        @(posedge clk);
        pop <= 1'b0;
    endtask
    function automatic logic [31:0] csr_v(input logic d, input logic f, input logic r,
        input logic [4:0] m);
        return {13'h0000, d, f, r, m, 11'h040};
    endfunction
    function automatic logic [31:0] cfg_v(input logic host, input urx_xfer_t ty, input logic hs);
        return {5'h00, 11'h040, 12'h000, hs, ty, host};
    endfunction
    // A hang is cut short well above the few hundred cycles the sequence needs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        nrst = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        pop = 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("split_rst", 32'h1, {26'h0, split});
        chk("uframe_rst", 32'h1, {26'h0, ufr});
        rd_chk("csr_rst", URX_OFS_CSR, 32'h0000_0000);
        rd_chk("irq_stat_rst", URX_OFS_IRQ_STAT, 32'h0000_0000);
        // Device role, isochronous: fill the two slots, then overrun.
        wr_reg(URX_OFS_CFG, cfg_v(1'b0, URX_ISO, 1'b0));
        wr_reg(URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b0, 5'h00));
        link.send_pkt(1'b1);
        #1;
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd_chk("csr_rdy", URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b1, 5'h00));
        wr_reg(URX_OFS_IRQ_EN, 32'h0000_0007);
        chk("irq_rdy", 32'h1, {31'h0, irq});
        wr_reg(URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b1, 5'h00));
        rd_chk("csr_keep", URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b1, 5'h00));
        link.gap_cyc = 5;
        link.send_pkt(1'b1);
        rd_chk("csr_full", URX_OFS_CSR, csr_v(1'b0, 1'b1, 1'b1, 5'h00));
        link.send_pkt(1'b1);
        rd_chk("csr_drop", URX_OFS_CSR, csr_v(1'b1, 1'b1, 1'b1, 5'h00));
        rd_chk("irq_drop", URX_OFS_IRQ_STAT, 32'h0000_0005);
        pop_pkt();
        rd_chk("csr_slot", URX_OFS_CSR, csr_v(1'b1, 1'b0, 1'b1, 5'h00));
        wr_reg(URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b0, 5'h00));
        rd_chk("csr_clr", URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b0, 5'h00));
        wr_reg(URX_OFS_IRQ_CLR, 32'h0000_0007);
        chk("irq_clr", 32'h0, {31'h0, irq});
        pop_pkt();
        link.gap_cyc = 0;
        // Device role, bulk: even a drop latched in iso mode reads as zero.
        wr_reg(URX_OFS_CFG, cfg_v(1'b0, URX_BULK, 1'b0));
        repeat (3) link.send_pkt(1'b1);
        wr_reg(URX_OFS_CFG, cfg_v(1'b0, URX_ISO, 1'b0));
        link.send_pkt(1'b1);
        wr_reg(URX_OFS_CFG, cfg_v(1'b0, URX_BULK, 1'b0));
        rd_chk("csr_bulk", URX_OFS_CSR, csr_v(1'b0, 1'b1, 1'b1, 5'h00));
        repeat (2) pop_pkt();
        wr_reg(URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b0, 5'h00));
        wr_reg(URX_OFS_IRQ_CLR, 32'h0000_0007);
        // Host role: third failed attempt raises the error on bulk and interrupt, not on isochronous.
        for (int t = 0; t < 3; t++) begin
            wr_reg(URX_OFS_CFG, cfg_v(1'b1, t == 0 ? URX_BULK : t == 1 ? URX_INTR : URX_ISO, 1'b0));
            repeat (2) link.send_pkt(1'b0);
            rd_chk("csr_two_fail", URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b0, 5'h00));
            link.send_pkt(1'b0);
            rd_chk("csr_err", URX_OFS_CSR, csr_v(t < 2, 1'b0, 1'b0, 5'h00));
            rd_chk("irq_err", URX_OFS_IRQ_STAT, {30'h0, t < 2, 1'b0});
            wr_reg(URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b0, 5'h00));
            wr_reg(URX_OFS_IRQ_CLR, 32'h0000_0007);
            link.send_fails(3);
            rd_chk("csr_err_run", URX_OFS_CSR, csr_v(t < 2, 1'b0, 1'b0, 5'h00));
            wr_reg(URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b0, 5'h00));
            wr_reg(URX_OFS_IRQ_CLR, 32'h0000_0007);
        end
        // Multiplier decoding over every transfer type, speed and edge value.
        for (int hs = 0; hs < 2; hs++) begin
            for (int t = 0; t < 4; t++) begin
                for (int m = 0; m < 4; m++) begin
                    wr_reg(URX_OFS_CFG, cfg_v(1'b0, urx_xfer_t'(t), hs[0]));
                    wr_reg(URX_OFS_CSR, csr_v(1'b0, 1'b0, 1'b0, mults[m]));
                    repeat (2) @(posedge clk);
                    #1;
                    exp_s = (t == 2) ? {1'b0, mults[m]} + 6'h01 : 6'h01;
                    exp_u = (hs == 1 && (t == 1 || t == 3)) ? (mults[m] == 5'h02 ? 6'h02 : 6'h03)
                        : 6'h01;
                    chk("payload", 32'h40 * ({27'h0, mults[m]} + 32'h1), {16'h0, payload});
                    chk("split_cnt", {26'h0, exp_s}, {26'h0, split});
                    chk("uframe_max", {26'h0, exp_u}, {26'h0, ufr});
                end
            end
        end
        // A second reset in mid-run must bring CSR, CFG, interrupt enable and the payload and split outputs back to their reset values.
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("payload_rst2", 32'h0, {16'h0, payload});
        chk("split_rst2", 32'h1, {26'h0, split});
        rd_chk("cfg_rst2", URX_OFS_CFG, {28'h0000000, 1'b0, URX_BULK, 1'b0});
        rd_chk("irq_en_rst2", URX_OFS_IRQ_EN, 32'h0000_0000);
        rd_chk("csr_rst2", URX_OFS_CSR, 32'h0000_0000);
        // Full width of the payload field, and an unmapped address.
        wr_reg(URX_OFS_CSR, {16'h0000, 5'h1F, 11'h7FE});
        rd_chk("csr_maxp", URX_OFS_CSR, {16'h0000, 5'h1F, 11'h7FE});
        wr_reg(4'h2, 32'hFFFF_FFFF);
        rd_chk("unmapped", 4'h2, 32'h0000_0000);
        final_report();
    end
endmodule // test_urx_top
`default_nettype wire
